// file: core/ccx_exec.sv
// ccx_exec.sv: executes call, memory clear, bit clear, watchdog clears and complement
// assumes a decoder presents one instruction at a time and honours instr_ready;
// data memory reads return in the cycle after rd_addr is presented.
//
// Contract
// - call pushes program counter plus one
// - call loads target into program counter with the push
// - call takes two instruction cycles
// - clear memory writes 00H, flags untouched
// - bit clear zeroes selected bit only
// - single watchdog clear resets counter, both flags
// - alternating pre-clear pair clears watchdog, flags
// - repeated same pre-clear has no effect
// - complement inverts every bit of byte
// - pair flags cleared only after consecutive pair
//
// operations in brief: a call pushes the return address and loads the
// target together; a byte clear writes zero without looking at memory;
// a bit clear and a complement read the byte first and write it back.
// watchdog forms touch only the counter clear pulse and the two flags.
//
// timing: an instruction is taken on the edge where valid meets ready;
// watchdog forms answer on that same edge, call and memory ops one edge later,
// with ready low for the busy cycle in between.
// flags are levels: a set event from the timer or the halt path beats a
// clear issued in the same cycle, so a late expiry is never lost.
// limitation: rd_data has no valid qualifier, so the memory must answer
// in exactly one cycle; a slower memory would need a wait input.
//
// ports in brief: instr is one struct from the decoder; rd_addr and
// rd_data are the read side of a single-port data memory, mem_wr its
// write side; flow carries push and program counter load together; wdt
// carries the counter clear pulse and both status flags.
`timescale 1ns/1ps
`include "ccx_defs.svh"

module ccx_exec (
  input  wire logic                 core_clk,        // 125 MHz instruction clock
  input  wire logic                 reset_n,         // synchronous, active low
  input  wire ccx_pkg::ccx_instr_t  instr,           // decoded instruction
  output logic                      instr_ready,     // unit idle, can take an instruction this cycle
  output logic [`CCX_ADDR_W-1:0]    rd_addr,         // data memory read address
  input  wire logic [`CCX_DATA_W-1:0] rd_data,       // read data, one cycle later
  output ccx_pkg::ccx_mem_wr_t      mem_wr,          // data memory write
  output ccx_pkg::ccx_flow_t        flow,            // stack push and pc load
  output ccx_pkg::ccx_wdt_t         wdt,             // watchdog clear and flags
  input  wire logic                 wdt_timeout_set, // watchdog expired event
  input  wire logic                 power_down_set,  // halt entered event
  output logic                      zero_flag_we,    // zero flag update strobe
  output logic                      zero_flag_value  // new zero flag value
);

  // whole state in one struct; outputs other than rd_addr and instr_ready are
  // read straight from it, so those outputs leave a flip-flop
  typedef struct packed {
    ccx_pkg::ccx_state_t  st;       // sequencer state
    ccx_pkg::ccx_instr_t  held;     // instruction in second cycle
    ccx_pkg::ccx_mem_wr_t mem_wr;   // registered write request
    ccx_pkg::ccx_flow_t   flow;     // registered flow request
    logic                 wdt_clr;  // registered counter clear
    logic                 tmo;      // timeout flag
    logic                 pwr;      // power-down flag
    logic                 z_we;     // zero flag update
    logic                 z_val;    // zero flag value
  } ccx_state_s_t;

  ccx_state_s_t state_reg;          // registered state
  ccx_state_s_t state_next;         // next state

  logic take;                       // instruction accepted
  logic pre_first;                  // pre-clear first strobe
  logic pre_second;                 // pre-clear second strobe
  logic pre_other;                  // anything else executed
  logic pair_done;                  // pair completed

  // byte with one bit forced low, used by the bit clear path
  function automatic logic [`CCX_DATA_W-1:0] clear_bit(
    input logic [`CCX_DATA_W-1:0] value,
    input logic [`CCX_BIT_W-1:0]  sel
  );
    logic [`CCX_DATA_W-1:0] mask;
    mask = `CCX_DATA_W'(1) << sel;
    return value & ~mask;
  endfunction

  // one's complement of a byte, shared by the write data and the zero flag
  function automatic logic [`CCX_DATA_W-1:0] complement_byte(
    input logic [`CCX_DATA_W-1:0] value
  );
    return value ^ `CCX_ONES_BYTE;
  endfunction

  // call and memory instructions spend a second cycle: call for the push,
  // bit clear and complement for read-modify-write; throughput traded for a single port
  assign take        = instr.valid && (state_reg.st == ccx_pkg::CCX_ST_IDLE);
  assign instr_ready = state_reg.st == ccx_pkg::CCX_ST_IDLE;
  // address goes straight out so the byte is back for the second cycle
  assign rd_addr     = instr.addr;
  assign pre_first   = take && (instr.op == ccx_pkg::CCX_OP_WDT_FIRST);
  assign pre_second  = take && (instr.op == ccx_pkg::CCX_OP_WDT_SECOND);
  assign pre_other   = take && !pre_first && !pre_second;

  // pairing tracker for the pre-clear forms; its pair_done is combinational
  // so the clear is registered on the same edge as the completing form
  ccx_preclear u_preclear (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .first_stb  (pre_first),
    .second_stb (pre_second),
    .other_stb  (pre_other),
    .pair_done  (pair_done)
  );

  // next-state logic: pulses default low, while the levels and the held
  // instruction keep their value unless a branch touches them
  always_comb begin
    state_next          = state_reg;
    state_next.mem_wr   = '0;
    state_next.flow     = '0;
    state_next.wdt_clr  = 1'b0;
    state_next.z_we     = 1'b0;
    // hardware sets the flags; a clear in the same cycle loses to the set
    if (wdt_timeout_set) begin
      state_next.tmo = 1'b1;
    end
    if (power_down_set) begin
      state_next.pwr = 1'b1;
    end
    case (state_reg.st)
      ccx_pkg::CCX_ST_IDLE: begin
        // idle: accept, then finish now or go busy for a second cycle
        if (take) begin
          state_next.held = instr;
          case (instr.op)
            ccx_pkg::CCX_OP_WDT_SINGLE: begin
              state_next.wdt_clr = 1'b1;
              state_next.tmo     = wdt_timeout_set;
              state_next.pwr     = power_down_set;
            end
            ccx_pkg::CCX_OP_WDT_FIRST,
            ccx_pkg::CCX_OP_WDT_SECOND: begin
              // only a completed pair touches counter or flags;
              // a lone or repeated form falls through untouched
              if (pair_done) begin
                state_next.wdt_clr = 1'b1;
                state_next.tmo     = wdt_timeout_set;
                state_next.pwr     = power_down_set;
              end
            end
            ccx_pkg::CCX_OP_NONE: begin
              // nothing to do
            end
            default: begin
              // call and memory ops need a second cycle
              state_next.st = ccx_pkg::CCX_ST_EXEC2;
            end
          endcase
        end
      end
      ccx_pkg::CCX_ST_EXEC2: begin
        // second cycle: the memory byte is valid now, finish the operation
        state_next.st = ccx_pkg::CCX_ST_IDLE;
        case (state_reg.held.op)
          ccx_pkg::CCX_OP_CALL: begin
            // return address pushed, no flag touched
            state_next.flow.push     = 1'b1;
            state_next.flow.ret_addr = state_reg.held.pc + `CCX_PC_STEP;
            state_next.flow.pc_load  = 1'b1;
            state_next.flow.pc_value = state_reg.held.target;
          end
          ccx_pkg::CCX_OP_ZERO_MEM: begin
            // whole byte written to zero, the read data is ignored
            state_next.mem_wr = '{1'b1, state_reg.held.addr, `CCX_ZERO_BYTE};
          end
          ccx_pkg::CCX_OP_ZERO_BIT: begin
            // read-modify-write keeps the other seven bits as they were
            state_next.mem_wr = '{1'b1, state_reg.held.addr,
                                  clear_bit(rd_data, state_reg.held.bit_sel)};
          end
          ccx_pkg::CCX_OP_INV_MEM: begin
            // inverted byte written back, zero flag follows the result
            state_next.mem_wr = '{1'b1, state_reg.held.addr,
                                  complement_byte(rd_data)};
            state_next.z_we   = 1'b1;
            state_next.z_val  = complement_byte(rd_data) == `CCX_ZERO_BYTE;
          end
          default: begin
            // no second-cycle work
          end
        endcase
      end
      default: begin
        state_next.st = ccx_pkg::CCX_ST_IDLE;
      end
    endcase
  end

  // register the state; reset is synchronous, so it acts only on an edge
  // and clears pulses, flags and the held instruction alike
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_reg     <= '0;
      state_reg.st  <= ccx_pkg::CCX_ST_IDLE;
      state_reg.tmo <= `CCX_FLAG_RST;
      state_reg.pwr <= `CCX_FLAG_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from flip-flops
  assign mem_wr                    = state_reg.mem_wr;
  assign flow                      = state_reg.flow;
  // one assignment for the whole watchdog struct keeps a single driver
  assign wdt = '{counter_clear:         state_reg.wdt_clr,
                 watchdog_timeout_flag: state_reg.tmo,
                 power_down_flag:       state_reg.pwr};
  assign zero_flag_we              = state_reg.z_we;
  assign zero_flag_value           = state_reg.z_val;

endmodule

// file: core/ccx_defs.svh
// ccx_defs.svh: offsets, widths, reset values and timing counts for the call/clear/complement unit
// assumes inclusion by bare name from core/ files
`ifndef CCX_DEFS_SVH
`define CCX_DEFS_SVH

`define CCX_PC_W          12
`define CCX_ADDR_W        8
`define CCX_DATA_W        8
`define CCX_BIT_W         3
`define CCX_PC_RST        12'h000
`define CCX_ZERO_BYTE     8'h00
`define CCX_ONES_BYTE     8'hFF
`define CCX_PC_STEP       12'h001
`define CCX_CALL_CYCLES   2
`define CCX_FLAG_RST      1'b0

`endif

// file: core/ccx_pkg.sv
// ccx_pkg.sv: types shared by the call/clear/complement execution unit
// assumes ccx_defs.svh is on the include path
`include "ccx_defs.svh"

package ccx_pkg;

  // operations this unit executes
  typedef enum logic [2:0] {
    CCX_OP_NONE       = 3'h0,
    CCX_OP_CALL       = 3'h1,
    CCX_OP_ZERO_MEM   = 3'h2,
    CCX_OP_ZERO_BIT   = 3'h3,
    CCX_OP_WDT_SINGLE = 3'h4,
    CCX_OP_WDT_FIRST  = 3'h5,
    CCX_OP_WDT_SECOND = 3'h6,
    CCX_OP_INV_MEM    = 3'h7
  } ccx_op_t;

  // execution sequencer, gray along idle -> read/call2 -> idle
  typedef enum logic [1:0] {
    CCX_ST_IDLE  = 2'b00,
    CCX_ST_EXEC2 = 2'b01
  } ccx_state_t;

  // last pre-clear seen, drives the alternation check
  typedef enum logic [1:0] {
    CCX_PRE_NONE   = 2'b00,
    CCX_PRE_FIRST  = 2'b01,
    CCX_PRE_SECOND = 2'b11
  } ccx_pre_t;

  // decoded instruction from the fetch path
  typedef struct packed {
    logic                     valid;
    ccx_op_t                  op;
    logic [`CCX_PC_W-1:0]     pc;
    logic [`CCX_PC_W-1:0]     target;
    logic [`CCX_ADDR_W-1:0]   addr;
    logic [`CCX_BIT_W-1:0]    bit_sel;
  } ccx_instr_t;

  // data memory write request
  typedef struct packed {
    logic                     we;
    logic [`CCX_ADDR_W-1:0]   addr;
    logic [`CCX_DATA_W-1:0]   data;
  } ccx_mem_wr_t;

  // stack push plus program counter load
  typedef struct packed {
    logic                     push;
    logic [`CCX_PC_W-1:0]     ret_addr;
    logic                     pc_load;
    logic [`CCX_PC_W-1:0]     pc_value;
  } ccx_flow_t;

  // watchdog side outputs
  typedef struct packed {
    logic                     counter_clear;
    logic                     watchdog_timeout_flag;
    logic                     power_down_flag;
  } ccx_wdt_t;

endpackage

// file: core/ccx_preclear.sv
// ccx_preclear.sv: pairing tracker for the two watchdog pre-clear instructions
// assumes one-cycle strobes from the decoder, at most one per cycle
`timescale 1ns/1ps
`include "ccx_defs.svh"

module ccx_preclear (
  input  wire logic core_clk,      // system instruction clock
  input  wire logic reset_n,       // synchronous, active low
  input  wire logic first_stb,     // pre-clear first executed
  input  wire logic second_stb,    // pre-clear second executed
  input  wire logic other_stb,     // any other instruction executed
  output logic      pair_done      // pulse: alternating pair completed
);

  // whole state in one struct
  typedef struct packed {
    ccx_pkg::ccx_pre_t last;       // last pre-clear seen
  } ccx_pc_state_t;

  ccx_pc_state_t state_reg;        // registered state
  ccx_pc_state_t state_next;       // next state

  // pair completes when the opposite form follows directly
  always_comb begin
    state_next = state_reg;
    pair_done  = 1'b0;
    if (first_stb) begin
      // a repeat of the same form has no effect and keeps waiting
      if (state_reg.last == ccx_pkg::CCX_PRE_SECOND) begin
        pair_done       = 1'b1;
        state_next.last = ccx_pkg::CCX_PRE_NONE;
      end else begin
        state_next.last = ccx_pkg::CCX_PRE_FIRST;
      end
    end else if (second_stb) begin
      if (state_reg.last == ccx_pkg::CCX_PRE_FIRST) begin
        pair_done       = 1'b1;
        state_next.last = ccx_pkg::CCX_PRE_NONE;
      end else begin
        state_next.last = ccx_pkg::CCX_PRE_SECOND;
      end
    end else if (other_stb) begin
      // consecutive means anything in between breaks the pair
      state_next.last = ccx_pkg::CCX_PRE_NONE;
    end
  end

  // register the state
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_reg.last <= ccx_pkg::CCX_PRE_NONE;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

// file: test/ccx_exec_props.sv
// ccx_exec_props.sv: port-level checks for the call/clear/complement unit
// assumes a bind onto ccx_exec, one clock domain, sync active-low reset
`timescale 1ns/1ps
`include "ccx_defs.svh"

module ccx_exec_props (
  input wire logic                     core_clk,
  input wire logic                     reset_n,
  input wire ccx_pkg::ccx_instr_t      instr,
  input wire logic                     instr_ready,
  input wire logic [`CCX_ADDR_W-1:0]   rd_addr,
  input wire logic [`CCX_DATA_W-1:0]   rd_data,
  input wire ccx_pkg::ccx_mem_wr_t     mem_wr,
  input wire ccx_pkg::ccx_flow_t       flow,
  input wire ccx_pkg::ccx_wdt_t        wdt,
  input wire logic                     wdt_timeout_set,
  input wire logic                     power_down_set,
  input wire logic                     zero_flag_we,
  input wire logic                     zero_flag_value
);
  logic take; // instruction accepted this cycle
  assign take = instr.valid && instr_ready;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_call_ret_push: assert property (take && instr.op == ccx_pkg::CCX_OP_CALL |-> ##2 flow.push
    && flow.ret_addr == $past(instr.pc, 2) + `CCX_PC_STEP) else $error("call return bad");
  a_call_target: assert property (take && instr.op == ccx_pkg::CCX_OP_CALL |-> ##2 flow.pc_load
    && flow.pc_value == $past(instr.target, 2)) else $error("call target bad");
  // busy cycle then free again, so the call costs exactly two cycles
  a_call_two_cycles: assert property (take && instr.op == ccx_pkg::CCX_OP_CALL |=> !instr_ready
    ##1 instr_ready) else $error("call length bad");
  a_zero_mem: assert property (take && instr.op == ccx_pkg::CCX_OP_ZERO_MEM |-> ##2 mem_wr.we
    && mem_wr.data == `CCX_ZERO_BYTE) else $error("zero write bad");
  a_zero_bit: assert property (take && instr.op == ccx_pkg::CCX_OP_ZERO_BIT |-> ##2 mem_wr.we
    && mem_wr.data == ($past(rd_data) & ~(8'h01 << $past(instr.bit_sel, 2))))
    else $error("bit clear bad");
  a_inv_write: assert property (take && instr.op == ccx_pkg::CCX_OP_INV_MEM |-> ##2 mem_wr.we
    && mem_wr.data == ~$past(rd_data) && zero_flag_we
    && zero_flag_value == (mem_wr.data == `CCX_ZERO_BYTE)) else $error("complement bad");
  // set events win over a clear, so only quiet cycles are judged
  a_wdt_single: assert property (take && instr.op == ccx_pkg::CCX_OP_WDT_SINGLE
    && !wdt_timeout_set && !power_down_set |=> wdt.counter_clear
    && !wdt.watchdog_timeout_flag && !wdt.power_down_flag) else $error("wdt clear bad");
  a_flags_hold: assert property (!wdt.counter_clear && !$past(wdt_timeout_set)
    && !$past(power_down_set) |-> $stable({wdt.watchdog_timeout_flag, wdt.power_down_flag}))
    else $error("flags moved");
  a_zflag_source: assert property (zero_flag_we |-> $past(take, 2)
    && $past(instr.op, 2) == ccx_pkg::CCX_OP_INV_MEM) else $error("zero flag stray");
  // a counter clear only ever follows a taken watchdog form
  a_clear_source: assert property (wdt.counter_clear |-> $past(take)
    && ($past(instr.op) == ccx_pkg::CCX_OP_WDT_SINGLE || $past(instr.op) == ccx_pkg::CCX_OP_WDT_FIRST
    || $past(instr.op) == ccx_pkg::CCX_OP_WDT_SECOND)) else $error("stray clear");
endmodule

bind ccx_exec ccx_exec_props chk_u (.core_clk(core_clk), .reset_n(reset_n), .instr(instr),
  .instr_ready(instr_ready), .rd_addr(rd_addr), .rd_data(rd_data), .mem_wr(mem_wr),
  .flow(flow), .wdt(wdt), .wdt_timeout_set(wdt_timeout_set),
  .power_down_set(power_down_set), .zero_flag_we(zero_flag_we),
  .zero_flag_value(zero_flag_value));

// file: test/call_clear_complement_exec_tb.sv
// call_clear_complement_exec_tb.sv: directed bench for ccx_exec
// assumes memory answers one cycle after rd_addr; inputs change on falling edges
`timescale 1ns/1ps
`include "ccx_defs.svh"

module call_clear_complement_exec_tb;
  logic                  core_clk;        // 8 ns clock
  logic                  reset_n;         // sync, active low
  ccx_pkg::ccx_instr_t   instr;           // decoded instruction driven here
  logic                  instr_ready;     // unit can take
  logic [7:0]            rd_addr;         // memory read address
  logic [7:0]            rd_data;         // memory read data
  logic [7:0]            addr_q;          // address latched by the memory stand-in
  ccx_pkg::ccx_mem_wr_t  mem_wr;          // write request
  ccx_pkg::ccx_flow_t    flow;            // push and pc load
  ccx_pkg::ccx_wdt_t     wdt;             // watchdog side
  logic                  wdt_timeout_set; // expiry event
  logic                  power_down_set;  // halt event
  logic                  zero_flag_we;    // zero flag strobe
  logic                  zero_flag_value; // zero flag value
  int                    n_errors;        // mismatches
  int                    n_tests;         // comparisons
  int                    cycles;          // hang guard

  ccx_exec dut_u (.core_clk(core_clk), .reset_n(reset_n), .instr(instr),
    .instr_ready(instr_ready), .rd_addr(rd_addr), .rd_data(rd_data), .mem_wr(mem_wr),
    .flow(flow), .wdt(wdt), .wdt_timeout_set(wdt_timeout_set),
    .power_down_set(power_down_set), .zero_flag_we(zero_flag_we),
    .zero_flag_value(zero_flag_value));

  // clock
  always #4 core_clk = ~core_clk;
  // memory stand-in: contents are address xor A5, so every byte is known
  always @(posedge core_clk) addr_q <= rd_addr;
  always @(negedge core_clk) rd_data <= addr_q ^ 8'hA5;
  // cut a hang short; the whole run needs about 60 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic summarize();
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // offer one instruction, return in the cycle after it was taken
  task automatic go(input ccx_pkg::ccx_op_t op, input logic [7:0] a, input logic [2:0] b);
    @(negedge core_clk);
    instr.valid = 1'b1;
    instr.op = op;
    instr.addr = a;
    instr.bit_sel = b;
    chk("ready", instr_ready, 12'h1);
    @(negedge core_clk);
    instr.valid = 1'b0;
  endtask

  // raise both flags through their event inputs
  task automatic set_flags();
    @(negedge core_clk);
    wdt_timeout_set = 1'b1;
    power_down_set = 1'b1;
    @(negedge core_clk);
    wdt_timeout_set = 1'b0;
    power_down_set = 1'b0;
    chk("flags set", {wdt.watchdog_timeout_flag, wdt.power_down_flag}, 12'h3);
  endtask

  // call from the top address: return address wraps to zero
  task automatic t_call();
    instr.pc = 12'hFFF;
    instr.target = 12'h123;
    go(ccx_pkg::CCX_OP_CALL, 8'h00, 3'h0);
    chk("busy", instr_ready, 12'h0);
    @(negedge core_clk);
    chk("push", {flow.push, flow.pc_load}, 12'h3);
    chk("ret", flow.ret_addr, 12'h000);
    chk("target", flow.pc_value, 12'h123);
    chk("free", instr_ready, 12'h1);
  endtask

  // whole-byte clear, every bit clear, complement with and without zero result
  task automatic t_mem();
    go(ccx_pkg::CCX_OP_ZERO_MEM, 8'h3C, 3'h0);
    @(negedge core_clk);
    chk("zero", {mem_wr.we, mem_wr.addr, mem_wr.data}, 20'h13C00);
    for (int i = 0; i < 8; i++) begin
      go(ccx_pkg::CCX_OP_ZERO_BIT, 8'hC3, 3'(i));
      @(negedge core_clk);
      chk("bit", {mem_wr.we, mem_wr.data}, {4'h1, 8'h66 & ~(8'h01 << i)});
    end
    go(ccx_pkg::CCX_OP_INV_MEM, 8'h5A, 3'h0);
    @(negedge core_clk);
    chk("inv", {mem_wr.we, mem_wr.data}, 12'h100);
    chk("zf", {zero_flag_we, zero_flag_value}, 12'h3);
    go(ccx_pkg::CCX_OP_INV_MEM, 8'h12, 3'h0);
    @(negedge core_clk);
    chk("inv", {mem_wr.we, mem_wr.addr, mem_wr.data}, 20'h11248);
    chk("inv", mem_wr.data, 12'h048);
    chk("zf", {zero_flag_we, zero_flag_value}, 12'h2);
  endtask

  // single clear, repeated pre-clear, broken pair, then a good pair
  task automatic t_wdt();
    set_flags();
    go(ccx_pkg::CCX_OP_WDT_SINGLE, 8'h00, 3'h0);
    chk("single", wdt, 12'h4);
    set_flags();
    go(ccx_pkg::CCX_OP_WDT_FIRST, 8'h00, 3'h0);
    chk("first", wdt, 12'h3);
    go(ccx_pkg::CCX_OP_WDT_FIRST, 8'h00, 3'h0);
    chk("repeat", wdt, 12'h3);
    go(ccx_pkg::CCX_OP_WDT_SECOND, 8'h00, 3'h0);
    chk("pair", wdt, 12'h4);
    set_flags();
    go(ccx_pkg::CCX_OP_WDT_SECOND, 8'h00, 3'h0);
    go(ccx_pkg::CCX_OP_NONE, 8'h00, 3'h0);
    go(ccx_pkg::CCX_OP_WDT_FIRST, 8'h00, 3'h0);
    chk("broken", wdt, 12'h3);
    go(ccx_pkg::CCX_OP_WDT_SECOND, 8'h00, 3'h0);
    chk("pair", wdt, 12'h4);
  endtask

  // main sequence
  initial begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    instr = '0;
    wdt_timeout_set = 1'b0;
    power_down_set = 1'b0;
    repeat (3) @(negedge core_clk);
    reset_n = 1'b1;
    t_call();
    t_mem();
    t_wdt();
    summarize();
  end
endmodule
